// ==== src/ppc_pkg.sv ====
// Contract
// - Every pin of a bidirectional port has its own direction bit; port 6 has them on pins 7:6 only, pins 3:0 are fixed outputs.
// - Port 0 works as two four-bit timed output groups fed from a buffer.
// - Port 2 is input only; one bit enables pull-ups on its upper six pins.
// - Ports 0 to 6 offer pull-ups on their inputs under software control.
// - One pull-up bit per port pulls up only that port's pins in input mode.
//
// Purpose: Constants for the parallel port block.
// Assumes: AXI4-Lite, 32-bit data, one word per register.
// Notes: Direction bit 1 means input.
package ppc_pkg;
  localparam int NPORT = 5;
  // Bank slot of each bidirectional port
  localparam int SLOT_P0 = 0;
  localparam int SLOT_P1 = 1;
  localparam int SLOT_P3 = 2;
  localparam int SLOT_P6 = 3;
  localparam int SLOT_P7 = 4;
  // Byte addresses
  localparam logic [7:0] OFS_DATA0 = 8'h00;
  localparam logic [7:0] OFS_DIR0 = 8'h20;
  localparam logic [7:0] OFS_PULLUP = 8'h40;
  localparam logic [7:0] OFS_RTO_CTRL = 8'h44;
  localparam logic [7:0] OFS_RTO_BUF = 8'h48;
  localparam logic [7:0] OFS_PORT2_IN = 8'h4c;
  localparam logic [7:0] PORT_STRIDE = 8'h04;
  // Pull-up register fields: bit n serves port n
  localparam int PU_P0 = 0;
  localparam int PU_P1 = 1;
  localparam int PU_P2 = 2;
  localparam int PU_P3 = 3;
  localparam int PU_P6 = 6;
  localparam logic [6:0] PU_MASK = 7'h4f;
  // Real-time output control fields
  localparam int RTO_LO = 0;
  localparam int RTO_HI = 1;
  // Port 6 layout
  localparam logic [7:0] P6_BIDIR_MASK = 8'hc0;
  localparam logic [7:0] P6_ABSENT_MASK = 8'h30;
  // Reset values
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [6:0] RST_PULLUP = 7'h00;
  localparam logic [1:0] RST_RTO_CTRL = 2'h0;
  localparam logic [7:0] RST_RTO_BUF = 8'h00;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ppc_pkg

// ==== src/ppc_pin_if.sv ====
// Purpose: Carries register state to the pin stage and pin state back.
// Assumes: One entry per bidirectional port.
// Notes: Direction bit 1 means input.
`timescale 1ns/10ps
interface ppc_pin_if #(parameter int NP = 5);
  logic [NP-1:0][7:0] latch;
  logic [NP-1:0][7:0] dir;
  logic [NP-1:0] pu_en;
  logic [NP-1:0][7:0] pin_in;
  logic [NP-1:0][7:0] pin_out;
  logic [NP-1:0][7:0] pin_oe;
  logic [NP-1:0][7:0] pin_pu;
  logic [NP-1:0][7:0] in_val;
  modport regs (output latch, dir, pu_en, pin_in,
    input pin_out, pin_oe, pin_pu, in_val);
  modport pins (input latch, dir, pu_en, pin_in,
    output pin_out, pin_oe, pin_pu, in_val);
endinterface : ppc_pin_if

// ==== src/ppc_pin_bank.sv ====
// Purpose: Registered pin stage for all bidirectional ports.
// Assumes: Pins synchronous to clk_in.
// Notes: Every pin output is a flip-flop.
`timescale 1ns/10ps
module ppc_pin_bank #(
  parameter int NP = 5
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  ppc_pin_if.pins bus
);
  import ppc_pkg::*;

  // ----------------------------------------------------------------
  // Per-bit pin stage
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NP * 8; g++) begin : g_bit
    localparam int P = g / 8;
    localparam int B = g % 8;
    logic out_ff;
    logic oe_ff;
    logic pu_ff;
    logic in_ff;
    // Pull-up only while the pin is an input
    wire nxt_pu = bus.pu_en[P] & bus.dir[P][B];
    always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        out_ff <= 1'b0;
        oe_ff <= 1'b0;
        pu_ff <= 1'b0;
        in_ff <= 1'b0;
      end else begin
        out_ff <= bus.latch[P][B];
        oe_ff <= ~bus.dir[P][B];
        pu_ff <= nxt_pu;
        in_ff <= bus.pin_in[P][B];
      end
    end
    assign bus.pin_out[P][B] = out_ff;
    assign bus.pin_oe[P][B] = oe_ff;
    assign bus.pin_pu[P][B] = pu_ff;
    assign bus.in_val[P][B] = in_ff;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_pu_input_only;
    @(posedge clk_in) disable iff (!resetn_in)
    ##1 (bus.pin_pu != '0) |-> ((bus.pin_pu & bus.pin_oe) == '0);
  endproperty
  a_pu_input_only: assert property (p_pu_input_only)
    else $error("pull-up active on a driven pin");
  property p_oe_follows_dir;
    @(posedge clk_in) disable iff (!resetn_in)
    resetn_in |=> (bus.pin_oe == ~$past(bus.dir));
  endproperty
  a_oe_follows_dir: assert property (p_oe_follows_dir)
    else $error("output enable does not follow direction");
endmodule : ppc_pin_bank

// ==== src/ppc_port_top.sv ====
// Purpose: Parallel ports with direction, pull-up and timed port 0 output.
// Assumes: AXI4-Lite slave; one write and one read outstanding.
// Notes: Trigger pulses for the timed groups come from outside.
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module ppc_port_top (
  input wire logic clk_in,
  input wire logic resetn_in,
  // AXI4-Lite
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Timed output triggers, bit 0 lower group, bit 1 upper group
  input wire logic [1:0] rto_trig_in,
  // Port 0
  input wire logic [7:0] port0_pins_in,
  output logic [7:0] port0_pins_out,
  output logic [7:0] port0_pins_oe_out,
  output logic [7:0] port0_pullup_out,
  // Port 1
  input wire logic [7:0] port1_pins_in,
  output logic [7:0] port1_pins_out,
  output logic [7:0] port1_pins_oe_out,
  output logic [7:0] port1_pullup_out,
  // Port 2, input only
  input wire logic [7:0] input_only_port_pins_in,
  output logic [5:0] input_port_upper_six_pins_pullup_out,
  // Port 3
  input wire logic [7:0] port3_pins_in,
  output logic [7:0] port3_pins_out,
  output logic [7:0] port3_pins_oe_out,
  output logic [7:0] port3_pullup_out,
  // Port 6
  output logic [3:0] output_only_group_pins_out,
  input wire logic [1:0] port6_bidirectional_pins_in,
  output logic [1:0] port6_bidirectional_pins_out,
  output logic [1:0] port6_bidirectional_pins_oe_out,
  output logic [1:0] port6_bidirectional_pullup_out,
  // Port 7
  input wire logic [7:0] port7_pins_in,
  output logic [7:0] port7_pins_out,
  output logic [7:0] port7_pins_oe_out
);
  import ppc_pkg::*;

  ppc_pin_if #(.NP(NPORT)) pif ();

  logic [NPORT-1:0][7:0] latch_ff;
  logic [NPORT-1:0][7:0] dir_ff;
  logic [6:0] pullup_ff;
  logic [1:0] rto_ctrl_ff;
  logic [7:0] rto_buf_ff;
  logic [5:0] p2_pu_ff;
  logic [7:0] p2_in_ff;
  logic [7:0] awaddr_ff;
  logic aw_got_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic w_got_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // ----------------------------------------------------------------
  // Write channel handshakes
  // ----------------------------------------------------------------
  wire aw_hs = s_axi_awvalid_in & awready_ff;
  wire w_hs = s_axi_wvalid_in & wready_ff;
  wire wr_do = aw_got_ff & w_got_ff;
  wire nxt_aw_got = (aw_got_ff | aw_hs) & ~wr_do;
  wire nxt_w_got = (w_got_ff | w_hs) & ~wr_do;
  wire nxt_bvalid = wr_do | (bvalid_ff & ~s_axi_bready_in);
  wire wr_lane = wr_do & wstrb_ff[0];
  wire [7:0] wbyte = wdata_ff[7:0];

  // Write address decode
  wire [7:0] wofs = awaddr_ff & 8'hfc;
  wire wr_pu = wofs == OFS_PULLUP;
  wire wr_rctl = wofs == OFS_RTO_CTRL;
  wire wr_rbuf = wofs == OFS_RTO_BUF;
  logic [NPORT-1:0] wr_data;
  logic [NPORT-1:0] wr_dir;
  for (genvar p = 0; p < NPORT; p++) begin : g_wdec
    assign wr_data[p] = wofs == OFS_DATA0 + PORT_STRIDE * 8'(p);
    assign wr_dir[p] = wofs == OFS_DIR0 + PORT_STRIDE * 8'(p);
  end
  wire wr_hit = (|wr_data) | (|wr_dir) | wr_pu | wr_rctl | wr_rbuf |
    (wofs == OFS_PORT2_IN);

  // Write-side bus registers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      if (aw_hs) awaddr_ff <= s_axi_awaddr_in;
      if (w_hs) begin
        wdata_ff <= s_axi_wdata_in;
        wstrb_ff <= s_axi_wstrb_in;
      end
      awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
      wready_ff <= ~nxt_w_got & ~nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      if (wr_do) bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // Port registers
  // ----------------------------------------------------------------
  // Port 0 nibble g loads from the buffer on its trigger when timed
  logic [7:0] nxt_latch0;
  for (genvar g = 0; g < 2; g++) begin : g_rto
    wire rto_on = rto_ctrl_ff[g];
    wire [3:0] cur = latch_ff[SLOT_P0][g*4 +: 4];
    wire [3:0] wr_nib = wbyte[g*4 +: 4];
    wire [3:0] buf_nib = rto_buf_ff[g*4 +: 4];
    wire do_sw = wr_lane & wr_data[SLOT_P0] & ~rto_on;
    assign nxt_latch0[g*4 +: 4] = (rto_on & rto_trig_in[g]) ? buf_nib :
      do_sw ? wr_nib : cur;
  end

  // Latches, directions, pull-ups and timed-output control
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      latch_ff <= {NPORT{RST_LATCH}};
      dir_ff <= {NPORT{RST_DIR}};
      pullup_ff <= RST_PULLUP;
      rto_ctrl_ff <= RST_RTO_CTRL;
      rto_buf_ff <= RST_RTO_BUF;
    end else begin
      latch_ff[SLOT_P0] <= nxt_latch0;
      for (int p = 1; p < NPORT; p++) begin
        if (wr_lane & wr_data[p]) latch_ff[p] <= wbyte;
      end
      for (int p = 0; p < NPORT; p++) begin
        if (wr_lane & wr_dir[p]) dir_ff[p] <= wbyte;
      end
      if (wr_lane & wr_pu) pullup_ff <= wbyte[6:0] & PU_MASK;
      if (wr_lane & wr_rctl) rto_ctrl_ff <= wbyte[1:0];
      if (wr_lane & wr_rbuf) rto_buf_ff <= wbyte;
    end
  end

  // ----------------------------------------------------------------
  // Pin stage hookup
  // ----------------------------------------------------------------
  // Port 6: low nibble always output, bits 5:4 absent
  wire [7:0] dir6 = (dir_ff[SLOT_P6] & P6_BIDIR_MASK) | P6_ABSENT_MASK;
  assign pif.latch = latch_ff;
  assign pif.dir = {dir_ff[SLOT_P7], dir6, dir_ff[SLOT_P3],
    dir_ff[SLOT_P1], dir_ff[SLOT_P0]};
  assign pif.pu_en = {1'b0, pullup_ff[PU_P6], pullup_ff[PU_P3],
    pullup_ff[PU_P1], pullup_ff[PU_P0]};
  assign pif.pin_in = {port7_pins_in,
    {port6_bidirectional_pins_in, 6'h00}, port3_pins_in, port1_pins_in,
    port0_pins_in};

  ppc_pin_bank #(.NP(NPORT)) u_bank (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .bus(pif.pins)
  );

  // Port 2 pull-ups switch as one group on the upper six pins
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      p2_pu_ff <= 6'h00;
      p2_in_ff <= 8'h00;
    end else begin
      p2_pu_ff <= {6{pullup_ff[PU_P2]}};
      p2_in_ff <= input_only_port_pins_in;
    end
  end

  // Pin outputs
  assign port0_pins_out = pif.pin_out[SLOT_P0];
  assign port0_pins_oe_out = pif.pin_oe[SLOT_P0];
  assign port0_pullup_out = pif.pin_pu[SLOT_P0];
  assign port1_pins_out = pif.pin_out[SLOT_P1];
  assign port1_pins_oe_out = pif.pin_oe[SLOT_P1];
  assign port1_pullup_out = pif.pin_pu[SLOT_P1];
  assign port3_pins_out = pif.pin_out[SLOT_P3];
  assign port3_pins_oe_out = pif.pin_oe[SLOT_P3];
  assign port3_pullup_out = pif.pin_pu[SLOT_P3];
  assign output_only_group_pins_out = pif.pin_out[SLOT_P6][3:0];
  assign port6_bidirectional_pins_out = pif.pin_out[SLOT_P6][7:6];
  assign port6_bidirectional_pins_oe_out = pif.pin_oe[SLOT_P6][7:6];
  assign port6_bidirectional_pullup_out = pif.pin_pu[SLOT_P6][7:6];
  assign port7_pins_out = pif.pin_out[SLOT_P7];
  assign port7_pins_oe_out = pif.pin_oe[SLOT_P7];
  assign input_port_upper_six_pins_pullup_out = p2_pu_ff;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Data reads show the pin for inputs and the latch for outputs
  wire [7:0] rofs = s_axi_araddr_in & 8'hfc;
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    if (rofs == OFS_PULLUP) rd_mux = {25'h0, pullup_ff};
    else if (rofs == OFS_RTO_CTRL) rd_mux = {30'h0, rto_ctrl_ff};
    else if (rofs == OFS_RTO_BUF) rd_mux = {24'h0, rto_buf_ff};
    else if (rofs == OFS_PORT2_IN) rd_mux = {24'h0, p2_in_ff};
    else rd_hit = 1'b0;
    for (int p = 0; p < NPORT; p++) begin
      if (rofs == OFS_DATA0 + PORT_STRIDE * 8'(p)) begin
        rd_hit = 1'b1;
        rd_mux = {24'h0, (pif.in_val[p] & pif.dir[p]) |
          (latch_ff[p] & ~pif.dir[p])};
      end
      if (rofs == OFS_DIR0 + PORT_STRIDE * 8'(p)) begin
        rd_hit = 1'b1;
        rd_mux = {24'h0, dir_ff[p]};
      end
    end
  end

  wire ar_hs = s_axi_arvalid_in & arready_ff;
  wire nxt_rvalid = ar_hs | (rvalid_ff & ~s_axi_rready_in);

  // Read-side bus registers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= RESP_OKAY;
    end else begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_hs) begin
        rdata_ff <= rd_mux;
        rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready_out = awready_ff;
  assign s_axi_wready_out = wready_ff;
  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out = bresp_ff;
  assign s_axi_arready_out = arready_ff;
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rdata_out = rdata_ff;
  assign s_axi_rresp_out = rresp_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_lo_trig;
    rto_ctrl_ff[RTO_LO] && rto_trig_in[RTO_LO];
  endsequence
  property p_rto_lo;
    @(posedge clk_in) disable iff (!resetn_in)
    s_lo_trig |=> latch_ff[SLOT_P0][3:0] == $past(rto_buf_ff[3:0])
      ##1 port0_pins_out[3:0] == $past(rto_buf_ff[3:0], 2);
  endproperty
  a_rto_lo: assert property (p_rto_lo)
    else $error("lower timed group not loaded from buffer");
  property p_rto_hi_no_sw;
    @(posedge clk_in) disable iff (!resetn_in)
    rto_ctrl_ff[RTO_HI] && !rto_trig_in[RTO_HI] |=>
      $stable(latch_ff[SLOT_P0][7:4]);
  endproperty
  a_rto_hi_no_sw: assert property (p_rto_hi_no_sw)
    else $error("upper timed group changed without trigger");
  property p_p2_pullup;
    @(posedge clk_in) disable iff (!resetn_in)
    1'b1 |=> input_port_upper_six_pins_pullup_out ==
      {6{$past(pullup_ff[PU_P2])}};
  endproperty
  a_p2_pullup: assert property (p_p2_pullup)
    else $error("port 2 pull-up group mismatch");
  property p_p1_pullup;
    @(posedge clk_in) disable iff (!resetn_in)
    1'b1 |=> port1_pullup_out ==
      ($past(dir_ff[SLOT_P1]) & {8{$past(pullup_ff[PU_P1])}});
  endproperty
  a_p1_pullup: assert property (p_p1_pullup)
    else $error("port 1 pull-up not gated by input mode");
  property p_pu_off_no_pull;
    @(posedge clk_in) disable iff (!resetn_in)
    !pullup_ff[PU_P3] ##1 !pullup_ff[PU_P3] |-> port3_pullup_out == 8'h00;
  endproperty
  a_pu_off_no_pull: assert property (p_pu_off_no_pull)
    else $error("port 3 pulled up while disabled");
  property p_reset_state;
    @(posedge clk_in) $rose(resetn_in) |->
      dir_ff == {NPORT{RST_DIR}} && pullup_ff == RST_PULLUP;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("reset state not all inputs with pull-ups off");
  property p_dir_write;
    @(posedge clk_in) disable iff (!resetn_in)
    wr_lane && wr_dir[SLOT_P3] |=> ##1 port3_pins_oe_out == ~$past(wbyte, 2);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("port 3 direction write not applied per pin");
  property p_bresp;
    @(posedge clk_in) disable iff (!resetn_in)
    wr_do |=> s_axi_bvalid_out;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write response missing");
endmodule : ppc_port_top

// ==== tb/ppc_board_model.sv ====
// Purpose: Board circuitry seen by one eight-pin port of the block.
// Assumes: Chip drive wins, then board drive, then pull-up.
// Notes: An undriven pin without pull-up shows a toggling pattern.
`timescale 1ns/10ps
module ppc_board_model (
  input wire logic clk_in,
  input wire logic [7:0] drv_in,
  input wire logic [7:0] oe_in,
  input wire logic [7:0] pu_in,
  input wire logic [7:0] ext_en_in,
  input wire logic [7:0] ext_val_in,
  output logic [7:0] level_out
);
  logic [7:0] float_ff = 8'h55;

  // Floating level changes every cycle so nobody can rely on it
  always_ff @(posedge clk_in) begin
    float_ff <= ~float_ff;
  end

  // Wire level per pin
  assign level_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_val_in) |
    (~oe_in & ~ext_en_in & (pu_in | float_ff));
endmodule : ppc_board_model

// ==== tb/ppc_port_top_tb.sv ====
// Purpose: Self-checking bench for the parallel port block.
// Assumes: AXI4-Lite master tasks; board model on every port.
// Notes: Slots 0..4 are ports 0,1,3,6,7; slot 5 is port 2.
`timescale 1ns/10ps
module ppc_port_top_tb;
  import ppc_pkg::*;
  localparam logic [7:0] MSK [5] = '{8'hff, 8'hff, 8'hff, 8'hcf, 8'hff};
  localparam logic [7:0] FRC [5] = '{8'h00, 8'h00, 8'h00, 8'h0f, 8'h00};
  localparam logic [7:0] DIRP [5] = '{8'h96, 8'h69, 8'h3c, 8'h5a, 8'ha5};
  localparam logic [7:0] LAT [5] = '{8'h3c, 8'hc3, 8'h0f, 8'h3f, 8'h81};
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [1:0] rto_trig = 2'h0;
  logic [7:0] ext_en [6] = '{default: 8'h00};
  logic [7:0] ext_val [6] = '{default: 8'h00};
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, p6o, p6oe, p6pu;
  logic [31:0] rdata;
  logic [3:0] oonly;
  logic [5:0] p2pu;
  wire [7:0] drv_a [6];
  wire [7:0] oe_a [6];
  wire [7:0] pu_a [6];
  wire [7:0] lvl [6];
  int error_cnt = 0;
  int n_tests = 0;

  always #20 clk_in = ~clk_in;

  // ----------------------------------------
  // Design and board
  // ----------------------------------------
  ppc_port_top dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .rto_trig_in(rto_trig),
    .port0_pins_in(lvl[0]), .port0_pins_out(drv_a[0]),
    .port0_pins_oe_out(oe_a[0]), .port0_pullup_out(pu_a[0]),
    .port1_pins_in(lvl[1]), .port1_pins_out(drv_a[1]),
    .port1_pins_oe_out(oe_a[1]), .port1_pullup_out(pu_a[1]),
    .input_only_port_pins_in(lvl[5]),
    .input_port_upper_six_pins_pullup_out(p2pu),
    .port3_pins_in(lvl[2]), .port3_pins_out(drv_a[2]),
    .port3_pins_oe_out(oe_a[2]), .port3_pullup_out(pu_a[2]),
    .output_only_group_pins_out(oonly),
    .port6_bidirectional_pins_in(lvl[3][7:6]),
    .port6_bidirectional_pins_out(p6o),
    .port6_bidirectional_pins_oe_out(p6oe),
    .port6_bidirectional_pullup_out(p6pu),
    .port7_pins_in(lvl[4]), .port7_pins_out(drv_a[4]),
    .port7_pins_oe_out(oe_a[4]));

  // Pack odd-shaped ports into eight-pin slots
  assign drv_a[3] = {p6o, 2'b00, oonly};
  assign oe_a[3] = {p6oe, 2'b00, 4'hf};
  assign pu_a[3] = {p6pu, 6'h00};
  assign pu_a[4] = 8'h00;
  assign drv_a[5] = 8'h00;
  assign oe_a[5] = 8'h00;
  assign pu_a[5] = {p2pu, 2'b00};

  for (genvar g = 0; g < 6; g++) begin : g_board
    ppc_board_model u_board (.clk_in(clk_in), .drv_in(drv_a[g]),
      .oe_in(oe_a[g]), .pu_in(pu_a[g]), .ext_en_in(ext_en[g]),
      .ext_val_in(ext_val[g]), .level_out(lvl[g]));
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic results;
    $display("Checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: response %h, expected %h", $time, got, exp);
    end
  endtask : chk_resp

  task automatic ran_out;
    error_cnt++;
    $display("Error at %0t: bus wait ran out", $time);
    results();
  endtask : ran_out

  function automatic logic [7:0] ad(input logic [7:0] b, input int i);
    return b + PORT_STRIDE * 8'(i);
  endfunction : ad

  // Write one register and check the response
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge clk_in);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Local flag: bready itself only settles after the edge
    while (!done) begin
      @(posedge clk_in);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        chk_resp(bresp, er);
        bready <= 1'b0;
        done = 1'b1;
      end else if (n > 50) begin
        ran_out();
      end
    end
  endtask : wr

  // Read one register, compare masked data and response
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
    input logic [7:0] m, input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk_in);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        chk_resp(rresp, er);
        chk_val(rdata & {24'hffffff, m}, {24'h0, e & m});
        rready <= 1'b0;
        done = 1'b1;
      end else if (n > 50) begin
        ran_out();
      end
    end
  endtask : rd

  task automatic settle;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
  endtask : settle

  task automatic pulse(input logic [1:0] t);
    @(posedge clk_in);
    rto_trig <= t;
    @(posedge clk_in);
    rto_trig <= 2'h0;
    settle();
  endtask : pulse

  task automatic do_reset;
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'b1;
    settle();
    for (int i = 0; i < 5; i++) begin
      chk_val(oe_a[i] & ~FRC[i], 8'h00);
      chk_val(pu_a[i], 8'h00);
      rd(ad(OFS_DIR0, i), RST_DIR, 8'hff, RESP_OKAY);
    end
    chk_val(p2pu, 6'h00);
    rd(OFS_PULLUP, 8'h00, 8'hff, RESP_OKAY);
    rd(OFS_RTO_CTRL, 8'h00, 8'hff, RESP_OKAY);
  endtask : do_reset

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] ed;
    do_reset();
    for (int i = 0; i < 5; i++) begin
      wr(ad(OFS_DIR0, i), DIRP[i], RESP_OKAY);
      wr(ad(OFS_DATA0, i), LAT[i], RESP_OKAY);
      ext_en[i] <= DIRP[i] & ~FRC[i];
      ext_val[i] <= 8'ha5;
    end
    // Port 2: low pins driven by board, upper six left to pull-ups
    ext_en[5] <= 8'h03;
    ext_val[5] <= 8'h02;
    wr(OFS_PULLUP, 8'h7f, RESP_OKAY);
    settle();
    for (int i = 0; i < 5; i++) begin
      ed = DIRP[i] & ~FRC[i];
      chk_val(oe_a[i] & MSK[i], ~ed & MSK[i]);
      chk_val(drv_a[i] & ~ed & MSK[i], LAT[i] & ~ed & MSK[i]);
      chk_val(pu_a[i], (i < 4) ? (ed & MSK[i]) : 8'h00);
      rd(ad(OFS_DATA0, i), (ed & 8'ha5) | (~ed & LAT[i]), MSK[i],
        RESP_OKAY);
      rd(ad(OFS_DIR0, i), DIRP[i], 8'hff, RESP_OKAY);
    end
    chk_val(p2pu, 6'h3f);
    rd(OFS_PORT2_IN, 8'hfe, 8'hff, RESP_OKAY);
    rd(OFS_PULLUP, 8'h4f, 8'hff, RESP_OKAY);
    wr(OFS_PORT2_IN, 8'h00, RESP_OKAY);
    rd(OFS_PORT2_IN, 8'hfe, 8'hff, RESP_OKAY);
    // One pin of port 3 flipped alone
    wr(ad(OFS_DIR0, 2), 8'h3d, RESP_OKAY);
    settle();
    chk_val(oe_a[2], 8'hc2);
    chk_val(pu_a[2], 8'h3d);
    wr(OFS_PULLUP, 8'h00, RESP_OKAY);
    settle();
    for (int i = 0; i < 4; i++) begin
      chk_val(pu_a[i], 8'h00);
    end
    chk_val(p2pu, 6'h00);
    // Unmapped places
    wr(8'h14, 8'hff, RESP_SLVERR);
    rd(8'h14, 8'h00, 8'hff, RESP_SLVERR);
    rd(8'hfc, 8'h00, 8'hff, RESP_SLVERR);
    // Timed output groups on port 0
    ext_en[0] <= 8'h00;
    wr(ad(OFS_DIR0, 0), 8'h00, RESP_OKAY);
    wr(OFS_DATA0, 8'h00, RESP_OKAY);
    wr(OFS_RTO_CTRL, 8'h01, RESP_OKAY);
    wr(OFS_RTO_BUF, 8'h5a, RESP_OKAY);
    rd(OFS_RTO_BUF, 8'h5a, 8'hff, RESP_OKAY);
    pulse(2'b01);
    chk_val(drv_a[0], 8'h0a);
    pulse(2'b10);
    chk_val(drv_a[0], 8'h0a);
    wr(OFS_DATA0, 8'hff, RESP_OKAY);
    settle();
    chk_val(drv_a[0], 8'hfa);
    wr(OFS_RTO_CTRL, 8'h03, RESP_OKAY);
    wr(OFS_RTO_BUF, 8'hc3, RESP_OKAY);
    pulse(2'b10);
    chk_val(drv_a[0], 8'hca);
    pulse(2'b01);
    chk_val(drv_a[0], 8'hc3);
    wr(OFS_RTO_CTRL, 8'h00, RESP_OKAY);
    wr(OFS_DATA0, 8'h11, RESP_OKAY);
    settle();
    chk_val(drv_a[0], 8'h11);
    do_reset();
    results();
  end
endmodule : ppc_port_top_tb
